// file: hdl/vec_pkg.sv
// Constants and carrier types for the vector prefix decoder and its register file.
// Assumes a front end that has already framed the prefix bytes and opcode of each instruction.
package vec_pkg;

  localparam int unsigned WIDE_W     = 256;
  localparam int unsigned NARROW_W   = 128;
  localparam int unsigned REGS_LONG  = 16;
  localparam int unsigned REGS_SHORT = 8;
  localparam int unsigned REG_AW     = 4;

  // Compact map field codes
  localparam logic [4:0] MAP_0F   = 5'h01;
  localparam logic [4:0] MAP_0F38 = 5'h02;
  localparam logic [4:0] MAP_0F3A = 5'h03;

  // Compact SIMD prefix field codes
  localparam logic [1:0] PP_NONE = 2'h0;
  localparam logic [1:0] PP_66   = 2'h1;
  localparam logic [1:0] PP_F3   = 2'h2;
  localparam logic [1:0] PP_F2   = 2'h3;

  // Field positions inside the prefix payload bytes and the immediate byte
  localparam int unsigned POS_R    = 7;
  localparam int unsigned POS_X    = 6;
  localparam int unsigned POS_B    = 5;
  localparam int unsigned POS_W    = 7;
  localparam int unsigned POS_VVVV = 3;
  localparam int unsigned POS_L    = 2;
  localparam int unsigned POS_IMM3 = 4;

  localparam logic [WIDE_W-1:0] REG_RESET = '0;

  typedef enum logic [1:0] {
    CLS_NONE,
    CLS_BOTH,
    CLS_NARROW,
    CLS_PACKED_INT
  } op_class_t;

  typedef struct packed {
    logic       valid;
    logic       long_mode;
    logic       vector_extension_prefix;
    logic       prefix_three_byte;
    logic [7:0] prefix_b1;
    logic [7:0] prefix_b2;
    logic       legacy_pp_seen;
    logic [1:0] legacy_pp;
    logic [4:0] legacy_map;
    logic       register_extension_prefix;
    logic [3:0] ext_wrxb;
    logic [7:0] opcode;
    logic [7:0] modrm;
    logic [7:0] imm;
    logic       mem_op;
  } instr_t;

  typedef struct packed {
    logic              valid;
    logic              invalid_op;
    logic              is_prefixed;
    logic              len256;
    logic [4:0]        map;
    logic [1:0]        pp;
    logic [7:0]        opcode;
    logic              wide_w;
    logic [REG_AW-1:0] dest;
    logic [REG_AW-1:0] src1;
    logic [REG_AW-1:0] src2;
    logic              src2_is_reg;
    logic [REG_AW-1:0] src3;
    logic              src3_en;
    logic              gpr_op;
    logic              need_align;
  } dec_t;

  typedef struct packed {
    logic              valid;
    logic              long_mode;
    logic              is_prefixed;
    logic              len256;
    logic [REG_AW-1:0] dest;
    logic [WIDE_W-1:0] data;
  } wb_t;

  typedef struct packed {
    logic              long_mode;
    logic              narrow;
    logic [REG_AW-1:0] addr;
  } rd_req_t;

endpackage

// file: hdl/wide_vector_regfile.sv
// Storage of the wide vector registers, split in a low and a high half.
// Assumes the caller has already resolved which halves a write touches.
`timescale 1ns/1ps

module wide_vector_regfile (
  input  wire logic                                  clk_sys,
  input  wire logic                                  rst_n,
  input  wire logic                                  we_lo,
  input  wire logic                                  we_hi,
  input  wire logic                                  zero_hi,
  input  wire logic [vec_pkg::REG_AW-1:0]            waddr,
  input  wire logic [vec_pkg::WIDE_W-1:0]            wdata,
  input  wire vec_pkg::rd_req_t                      rd_a,
  input  wire vec_pkg::rd_req_t                      rd_b,
  output logic      [vec_pkg::WIDE_W-1:0]            q_a,
  output logic      [vec_pkg::WIDE_W-1:0]            q_b
);

  typedef struct packed {
    logic [vec_pkg::REGS_LONG-1:0][vec_pkg::NARROW_W-1:0] lo;
    logic [vec_pkg::REGS_LONG-1:0][vec_pkg::NARROW_W-1:0] hi;
    logic [vec_pkg::WIDE_W-1:0]                           q_a;
    logic [vec_pkg::WIDE_W-1:0]                           q_b;
  } rf_state_t;

  rf_state_t state;
  rf_state_t next_state;

  function automatic logic [vec_pkg::WIDE_W-1:0] view(
    input rf_state_t s,
    input vec_pkg::rd_req_t r
  );
    logic [vec_pkg::REG_AW-1:0] a;
    a = r.addr;
    if (!r.long_mode) begin
      a[vec_pkg::REG_AW-1] = 1'b0;
    end
    // The narrow view is the same low storage, never a copy
    if (r.narrow) begin
      view = {{vec_pkg::NARROW_W{1'b0}}, s.lo[a]};
    end else begin
      view = {s.hi[a], s.lo[a]};
    end
  endfunction

  always_comb begin
    next_state = state;
    if (we_lo) begin
      next_state.lo[waddr] = wdata[vec_pkg::NARROW_W-1:0];
    end
    if (zero_hi) begin
      next_state.hi[waddr] = '0;
    end else if (we_hi) begin
      next_state.hi[waddr] = wdata[vec_pkg::WIDE_W-1:vec_pkg::NARROW_W];
    end
    // Reads see the value before this cycle's write
    next_state.q_a = view(state, rd_a);
    next_state.q_b = view(state, rd_b);
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state.lo  <= '0;
      state.hi  <= '0;
      state.q_a <= vec_pkg::REG_RESET;
      state.q_b <= vec_pkg::REG_RESET;
    end else begin
      state <= next_state;
    end
  end

  assign q_a = state.q_a;
  assign q_b = state.q_b;

endmodule

// file: hdl/vector_prefix_decode_regfile.sv
// Decoder for prefixed and legacy vector operations, plus write-back into the wide registers.
// Assumes the front end has split off prefix bytes, opcode, modrm and immediate per instruction.
`timescale 1ns/1ps

module vector_prefix_decode_regfile (
  input  wire logic                       clk_sys,
  input  wire logic                       rst_n,
  input  wire vec_pkg::instr_t            instr,
  output vec_pkg::dec_t                   dec,
  input  wire vec_pkg::wb_t               wb,
  input  wire vec_pkg::rd_req_t           rd_a,
  input  wire vec_pkg::rd_req_t           rd_b,
  output logic [vec_pkg::WIDE_W-1:0]      rd_a_data,
  output logic [vec_pkg::WIDE_W-1:0]      rd_b_data
);

  typedef struct packed {
    vec_pkg::dec_t dec;
  } dec_state_t;

  dec_state_t state;
  dec_state_t next_state;

  vec_pkg::op_class_t cls;
  logic [4:0]         cls_bits;
  logic               cls_align;
  logic               cls_gpr;
  logic               cls_imm_reg;
  logic [4:0]         f_map;
  logic [1:0]         f_pp;
  logic               f_r;
  logic               f_x;
  logic               f_b;
  logic               f_w;
  logic               f_l;
  logic [3:0]         f_vvvv;
  logic               bad;
  logic               we_lo;
  logic               we_hi;
  logic               zero_hi;
  logic               wb_ok;

  // Opcode table for map 0F and the blend forms of map 0F3A.
  // Returns class, legacy alignment need, GPR operand, register in immediate.
  function automatic logic [4:0] classify(
    input logic [4:0] map,
    input logic [1:0] pp,
    input logic [7:0] opc
  );
    vec_pkg::op_class_t c;
    logic               al;
    logic               g;
    logic               ir;
    logic               sc;
    c  = vec_pkg::CLS_NONE;
    al = 1'b0;
    g  = 1'b0;
    ir = 1'b0;
    sc = (pp == vec_pkg::PP_F3) || (pp == vec_pkg::PP_F2);
    if (map == vec_pkg::MAP_0F) begin
      case (opc)
        8'h10, 8'h11: begin
          c = sc ? vec_pkg::CLS_NARROW : vec_pkg::CLS_BOTH;
        end
        8'h12: begin
          c = sc ? vec_pkg::CLS_BOTH : vec_pkg::CLS_NARROW;
        end
        8'h16: begin
          c = (pp == vec_pkg::PP_F3) ? vec_pkg::CLS_BOTH : vec_pkg::CLS_NARROW;
          c = (pp == vec_pkg::PP_F2) ? vec_pkg::CLS_NONE : c;
        end
        8'h13, 8'h17: begin
          c = sc ? vec_pkg::CLS_NONE : vec_pkg::CLS_NARROW;
        end
        8'h14, 8'h15, 8'h28, 8'h29, 8'h54, 8'h55, 8'h56, 8'h57: begin
          c  = sc ? vec_pkg::CLS_NONE : vec_pkg::CLS_BOTH;
          al = 1'b1;
        end
        8'h2a: begin
          c = sc ? vec_pkg::CLS_NARROW : vec_pkg::CLS_PACKED_INT;
          g = sc;
        end
        8'h2b: begin
          c  = sc ? vec_pkg::CLS_NONE : vec_pkg::CLS_NARROW;
          al = 1'b1;
        end
        8'h2c, 8'h2d: begin
          c = sc ? vec_pkg::CLS_NARROW : vec_pkg::CLS_PACKED_INT;
          g = sc;
        end
        8'h2e, 8'h2f: begin
          c = sc ? vec_pkg::CLS_NONE : vec_pkg::CLS_NARROW;
        end
        8'h50: begin
          c = sc ? vec_pkg::CLS_NONE : vec_pkg::CLS_BOTH;
          g = 1'b1;
        end
        8'h51, 8'h58, 8'h59, 8'h5a, 8'h5c, 8'h5d, 8'h5e, 8'h5f: begin
          c  = sc ? vec_pkg::CLS_NARROW : vec_pkg::CLS_BOTH;
          al = !sc;
        end
        8'h52, 8'h53: begin
          c = (pp == vec_pkg::PP_NONE) ? vec_pkg::CLS_BOTH : vec_pkg::CLS_NONE;
          c = (pp == vec_pkg::PP_F3) ? vec_pkg::CLS_NARROW : c;
          al = (pp == vec_pkg::PP_NONE);
        end
        8'h5b: begin
          c  = (pp == vec_pkg::PP_F2) ? vec_pkg::CLS_NONE : vec_pkg::CLS_BOTH;
          al = 1'b1;
        end
        default: begin
          c = vec_pkg::CLS_NONE;
        end
      endcase
    end else if (map == vec_pkg::MAP_0F3A && pp == vec_pkg::PP_66) begin
      case (opc)
        8'h4a, 8'h4b: begin
          c  = vec_pkg::CLS_BOTH;
          ir = 1'b1;
        end
        8'h4c: begin
          c  = vec_pkg::CLS_NARROW;
          ir = 1'b1;
        end
        default: begin
          c = vec_pkg::CLS_NONE;
        end
      endcase
    end
    classify = {c, al, g, ir};
  endfunction

  always_comb begin
    // The R, X, B and vvvv payload fields are stored inverted in the prefix bytes
    if (instr.prefix_three_byte) begin
      f_r    = ~instr.prefix_b1[vec_pkg::POS_R];
      f_x    = ~instr.prefix_b1[vec_pkg::POS_X];
      f_b    = ~instr.prefix_b1[vec_pkg::POS_B];
      f_map  = instr.prefix_b1[4:0];
      f_w    = instr.prefix_b2[vec_pkg::POS_W];
      f_vvvv = ~instr.prefix_b2[vec_pkg::POS_VVVV +: 4];
      f_l    = instr.prefix_b2[vec_pkg::POS_L];
      f_pp   = instr.prefix_b2[1:0];
    end else begin
      f_r    = ~instr.prefix_b1[vec_pkg::POS_R];
      f_x    = 1'b0;
      f_b    = 1'b0;
      f_map  = vec_pkg::MAP_0F;
      f_w    = 1'b0;
      f_vvvv = ~instr.prefix_b1[vec_pkg::POS_VVVV +: 4];
      f_l    = instr.prefix_b1[vec_pkg::POS_L];
      f_pp   = instr.prefix_b1[1:0];
    end
    if (!instr.vector_extension_prefix) begin
      f_r    = instr.register_extension_prefix & instr.ext_wrxb[2];
      f_x    = instr.register_extension_prefix & instr.ext_wrxb[1];
      f_b    = instr.register_extension_prefix & instr.ext_wrxb[0];
      f_w    = instr.register_extension_prefix & instr.ext_wrxb[3];
      f_map  = instr.legacy_map;
      f_pp   = instr.legacy_pp_seen ? instr.legacy_pp : vec_pkg::PP_NONE;
      f_vvvv = 4'h0;
      f_l    = 1'b0;
    end
    cls_bits    = classify(f_map, f_pp, instr.opcode);
    cls         = vec_pkg::op_class_t'(cls_bits[4:3]);
    cls_align   = cls_bits[2];
    cls_gpr     = cls_bits[1];
    cls_imm_reg = cls_bits[0];
  end

  always_comb begin
    next_state = state;
    next_state.dec.valid = instr.valid;
    bad = (cls == vec_pkg::CLS_NONE);
    if (instr.vector_extension_prefix) begin
      // Explicit extension or SIMD prefixes ahead of the vector prefix are illegal
      bad = bad || instr.register_extension_prefix || instr.legacy_pp_seen;
      bad = bad || (cls == vec_pkg::CLS_PACKED_INT);
      bad = bad || (f_l && cls != vec_pkg::CLS_BOTH);
      bad = bad || (f_map != vec_pkg::MAP_0F && f_map != vec_pkg::MAP_0F38
                    && f_map != vec_pkg::MAP_0F3A);
    end else begin
      // Legacy encodings do not reach the four-operand blend forms
      bad = bad || cls_imm_reg;
    end
    next_state.dec.invalid_op = instr.valid && bad;
    next_state.dec.is_prefixed = instr.vector_extension_prefix;
    next_state.dec.len256     = instr.vector_extension_prefix && f_l;
    next_state.dec.map        = f_map;
    next_state.dec.pp         = f_pp;
    next_state.dec.opcode     = instr.opcode;
    next_state.dec.wide_w     = f_w;
    // Outside 64-bit mode only the low eight registers exist
    next_state.dec.dest = {instr.long_mode & f_r, instr.modrm[5:3]};
    next_state.dec.src2 = {instr.long_mode & f_b & ~f_x, instr.modrm[2:0]};
    next_state.dec.src2_is_reg = !instr.mem_op;
    if (instr.vector_extension_prefix) begin
      next_state.dec.src1 = {instr.long_mode & f_vvvv[3], f_vvvv[2:0]};
    end else begin
      next_state.dec.src1 = next_state.dec.dest;
    end
    next_state.dec.src3    = {instr.long_mode & instr.imm[7], instr.imm[6:vec_pkg::POS_IMM3]};
    next_state.dec.src3_en = instr.vector_extension_prefix && cls_imm_reg;
    next_state.dec.gpr_op  = cls_gpr;
    // Prefixed forms keep strict alignment only for aligned moves and streaming stores
    if (instr.vector_extension_prefix) begin
      next_state.dec.need_align = instr.mem_op && (instr.opcode == 8'h28
        || instr.opcode == 8'h29 || instr.opcode == 8'h2b);
    end else begin
      next_state.dec.need_align = instr.mem_op && cls_align;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign dec = state.dec;

  // Write-back halves. Upper registers are silently dropped outside 64-bit mode.
  always_comb begin
    wb_ok   = wb.valid && (wb.long_mode || !wb.dest[vec_pkg::REG_AW-1]);
    we_lo   = wb_ok;
    we_hi   = wb_ok && wb.is_prefixed && wb.len256;
    zero_hi = wb_ok && wb.is_prefixed && !wb.len256;
    // Legacy writes leave the high half alone: neither strobe is raised
    if (!wb.is_prefixed) begin
      we_hi = 1'b0;
    end
  end

  wide_vector_regfile u_regs (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .we_lo   (we_lo),
    .we_hi   (we_hi),
    .zero_hi (zero_hi),
    .waddr   (wb.dest),
    .wdata   (wb.data),
    .rd_a    (rd_a),
    .rd_b    (rd_b),
    .q_a     (rd_a_data),
    .q_b     (rd_b_data)
  );

endmodule

// file: test/vpd_chk.sv
// Checker on the ports of the vector prefix decoder.
// Assumes one clock domain; bound from the bench top file.
`timescale 1ns/1ps

module vpd_chk (
  input wire logic                          clk_sys,
  input wire logic                          rst_n,
  input wire vec_pkg::instr_t               instr,
  input wire vec_pkg::dec_t                 dec,
  input wire vec_pkg::wb_t                  wb,
  input wire vec_pkg::rd_req_t              rd_a,
  input wire vec_pkg::rd_req_t              rd_b,
  input wire logic [vec_pkg::WIDE_W-1:0]    rd_a_data,
  input wire logic [vec_pkg::WIDE_W-1:0]    rd_b_data
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  wire logic iv = instr.valid & instr.vector_extension_prefix;
  wire logic i2 = iv & ~instr.prefix_three_byte;

  a_dec_follows: assert property ($past(rst_n) |-> dec.valid == $past(instr.valid))
    else $error("decode valid does not follow input");
  a_ext_refused: assert property (iv && instr.register_extension_prefix
    |=> dec.invalid_op) else $error("prefix with extension byte accepted");
  a_pp_refused: assert property (iv && instr.legacy_pp_seen |=> dec.invalid_op)
    else $error("prefix with legacy simd byte accepted");
  a_imm_src3: assert property (instr.valid && instr.long_mode
    |=> !dec.src3_en || dec.src3 == $past(instr.imm[7:4])) else $error("third source wrong");
  a_vvvv_src: assert property (i2 && instr.long_mode
    |=> dec.invalid_op || dec.src1 == ~$past(instr.prefix_b1[6:3])) else $error("source wrong");
  a_short_regs: assert property (instr.valid && !instr.long_mode
    |=> !dec.dest[3] && !dec.src1[3]) else $error("upper register in short mode");
  a_map_implied: assert property (i2
    |=> dec.invalid_op || dec.map == vec_pkg::MAP_0F) else $error("implied map wrong");
  a_narrow_view: assert property (rd_a.narrow |=> rd_a_data[255:128] == '0)
    else $error("narrow view shows upper half");
  a_pkint_refused: assert property (i2 && instr.opcode == 8'h2a && !instr.prefix_b1[1]
    |=> dec.invalid_op) else $error("packed integer conversion accepted");
  a_len_kept: assert property (i2
    |=> dec.invalid_op || dec.len256 == $past(instr.prefix_b1[2])) else $error("length wrong");

  cover property (dec.valid && dec.invalid_op);
  cover property (dec.valid && dec.src3_en);
  cover property (wb.valid && wb.is_prefixed && !wb.len256);
  cover property (dec.valid && dec.gpr_op && !dec.invalid_op);
endmodule

// file: test/front_end_model.sv
// Front end model: presents one framed instruction per cycle.
// Assumes the bench calls issue and idle; it drives at the falling edge.
`timescale 1ns/1ps

module front_end_model (
  input  wire logic      clk_sys,
  output vec_pkg::instr_t instr
);
  vec_pkg::instr_t last = '0;

  initial instr = '0;

  task automatic issue(input vec_pkg::instr_t i);
    @(negedge clk_sys);
    instr = i;
    last  = i;
  endtask

  // Idle fields carry the inverse of the last word, so stale values cannot pass
  task automatic idle();
    @(negedge clk_sys);
    instr = {1'b0, ~last[$bits(vec_pkg::instr_t)-2:0]};
  endtask
endmodule

// file: test/test_vector_prefix_decode_regfile.sv
// Bench for the vector prefix decoder and wide register file.
// Assumes one 10 MHz clock; the checker is bound at the foot.
`timescale 1ns/1ps

module test_vector_prefix_decode_regfile;
  logic                          clk_sys;
  logic                          rst_n = 1'b0;
  vec_pkg::instr_t               instr;
  vec_pkg::dec_t                 dec;
  vec_pkg::wb_t                  wb = '0;
  vec_pkg::rd_req_t              rd_a = '0;
  vec_pkg::rd_req_t              rd_b = '0;
  logic [vec_pkg::WIDE_W-1:0]    rd_a_data;
  logic [vec_pkg::WIDE_W-1:0]    rd_b_data;
  int                            error_cnt = 0;
  int                            checked = 0;
  int                            cyc = 0;
  // Opcode, pp code, length bit, refusal expected
  logic [11:0]                   tbl [10] = '{12'h582, 12'h580, 12'h58b, 12'h588, 12'h51f,
                                              12'h2a1, 12'h2a5, 12'h2b3, 12'h2b0, 12'h286};

  front_end_model fe (.clk_sys(clk_sys), .instr(instr));
  vector_prefix_decode_regfile uut (.clk_sys(clk_sys), .rst_n(rst_n), .instr(instr),
    .dec(dec), .wb(wb), .rd_a(rd_a), .rd_b(rd_b), .rd_a_data(rd_a_data),
    .rd_b_data(rd_b_data));

  task automatic chk(input logic [255:0] seen, input logic [255:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %0t: saw %0h expected %0h", $time, seen, exp);
    end
  endtask

  function automatic vec_pkg::instr_t pfx2(input logic [7:0] opc, input logic [1:0] pp,
                                           input logic l);
    vec_pkg::instr_t i;
    i = '0;
    i.valid = 1'b1;
    i.long_mode = 1'b1;
    i.vector_extension_prefix = 1'b1;
    i.prefix_b1 = {1'b0, ~4'h9, l, pp};
    i.opcode = opc;
    i.modrm = 8'hd3;
    return i;
  endfunction

  // Result stands in the cycle after the edge that took the instruction
  task automatic send(input vec_pkg::instr_t i);
    fe.issue(i);
    @(posedge clk_sys);
    #1;
  endtask

  task automatic wr(input logic lm, input logic vx, input logic l, input logic [3:0] d,
                    input logic [255:0] v);
    @(negedge clk_sys);
    wb = '{1'b1, lm, vx, l, d, v};
    @(negedge clk_sys);
    wb.valid = 1'b0;
  endtask

  task automatic rd(input logic lm, input logic [3:0] a);
    @(negedge clk_sys);
    rd_a = '{lm, 1'b0, a};
    rd_b = '{lm, 1'b1, a};
    @(posedge clk_sys);
    #1;
  endtask

  // Back to back decodes across both lengths
  task automatic t_len_table();
    for (int k = 0; k < 10; k++) begin
      send(pfx2(tbl[k][11:4], tbl[k][3:2], tbl[k][1]));
      chk(dec.valid, 1'b1);
      chk(dec.invalid_op, tbl[k][0]);
      if (!tbl[k][0]) begin
        chk(dec.len256, tbl[k][1]);
        chk(dec.pp, tbl[k][3:2]);
        chk(dec.opcode, tbl[k][11:4]);
        chk({dec.dest, dec.src1, dec.src2, dec.src2_is_reg}, 13'h1527);
      end
    end
    fe.idle();
  endtask

  task automatic t_maps();
    vec_pkg::instr_t i;
    i = pfx2(8'h4a, vec_pkg::PP_66, 1'b1);
    i.prefix_three_byte = 1'b1;
    // Second payload byte: W set, then the same vvvv, L and pp as the short form
    i.prefix_b2 = {1'b1, i.prefix_b1[6:0]};
    i.prefix_b1 = 8'h43;
    i.imm = 8'hc5;
    send(i);
    chk({dec.invalid_op, dec.map, dec.src3_en, dec.src3}, {7'h03, 1'b1, 4'hc});
    chk({dec.src1, dec.src2, dec.wide_w}, 9'h137);
    i.prefix_b1 = 8'h42;
    send(i);
    chk(dec.invalid_op, 1'b1);
    i.prefix_b1 = 8'h41;
    i.opcode = 8'h58;
    send(i);
    chk({dec.invalid_op, dec.map}, {1'b0, vec_pkg::MAP_0F});
    i = pfx2(8'h58, vec_pkg::PP_NONE, 1'b0);
    i.register_extension_prefix = 1'b1;
    send(i);
    chk(dec.invalid_op, 1'b1);
    i.register_extension_prefix = 1'b0;
    i.legacy_pp_seen = 1'b1;
    send(i);
    chk(dec.invalid_op, 1'b1);
    i.legacy_pp_seen = 1'b0;
    i.mem_op = 1'b1;
    i.modrm = 8'h13;
    send(i);
    chk({dec.invalid_op, dec.need_align, dec.src2_is_reg}, 3'h0);
    i.vector_extension_prefix = 1'b0;
    i.legacy_map = vec_pkg::MAP_0F;
    send(i);
    chk({dec.invalid_op, dec.is_prefixed, dec.need_align}, 3'h1);
    // Legacy extension byte and 66H still steer the unprefixed path
    i.register_extension_prefix = 1'b1;
    i.ext_wrxb = 4'hd;
    i.legacy_pp_seen = 1'b1;
    i.legacy_pp = vec_pkg::PP_66;
    send(i);
    chk({dec.invalid_op, dec.wide_w, dec.dest, dec.pp}, 8'h69);
    i = pfx2(8'h28, vec_pkg::PP_NONE, 1'b1);
    i.mem_op = 1'b1;
    send(i);
    chk({dec.invalid_op, dec.need_align}, 2'h1);
    i = pfx2(8'h50, vec_pkg::PP_66, 1'b1);
    send(i);
    chk({dec.invalid_op, dec.gpr_op, dec.len256}, 3'h3);
    i = pfx2(8'h58, vec_pkg::PP_NONE, 1'b1);
    i.long_mode = 1'b0;
    send(i);
    chk({dec.dest, dec.src1}, 8'h21);
    fe.idle();
  endtask

  task automatic t_regs();
    logic [255:0] a;
    logic [255:0] b;
    a = {16{16'hc3a5}};
    b = {16{16'h1e77}};
    wr(1'b1, 1'b1, 1'b1, 4'h5, a);
    wr(1'b1, 1'b0, 1'b0, 4'h5, b);
    rd(1'b1, 4'h5);
    chk(rd_a_data, {a[255:128], b[127:0]});
    chk(rd_b_data, {128'h0, b[127:0]});
    wr(1'b1, 1'b1, 1'b0, 4'h5, a);
    rd(1'b1, 4'h5);
    chk(rd_a_data, {128'h0, a[127:0]});
    wr(1'b0, 1'b1, 1'b1, 4'hc, a);
    rd(1'b1, 4'hc);
    chk(rd_a_data, 256'h0);
    wr(1'b1, 1'b1, 1'b1, 4'hc, b);
    rd(1'b0, 4'hc);
    chk(rd_a_data, 256'h0);
    rd(1'b1, 4'hc);
    chk(rd_a_data, b);
  endtask

  task automatic stop_test();
    $display("Checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  // Whole run needs about 45 cycles; a hang is cut well past that
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      stop_test();
    end
  end

  initial begin
    repeat (5) @(posedge clk_sys);
    @(negedge clk_sys);
    rst_n = 1'b1;
    t_len_table();
    t_maps();
    t_regs();
    stop_test();
  end
endmodule

bind vector_prefix_decode_regfile vpd_chk chk_i (.clk_sys(clk_sys), .rst_n(rst_n),
  .instr(instr), .dec(dec), .wb(wb), .rd_a(rd_a), .rd_b(rd_b), .rd_a_data(rd_a_data),
  .rd_b_data(rd_b_data));
